//--- design/tmr_timer.sv
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module tmr_timer
    import tmr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic slow_clock_pin,
    output logic compare_output_pin,
    output logic compare_output_override,
    output logic crystal_osc_enable
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [2:0] sync;
        logic slow_lvl;
        logic [6:0] ctl;
        logic [6:0] ctl_tmp;
        logic force_tmp;
        logic [7:0] cnt;
        logic [7:0] cnt_tmp;
        logic [7:0] cmp_tmp;
        logic [7:0] cmp_buf;
        logic [7:0] cmp_act;
        logic [2:0] pend;
        logic [2:0][1:0] ecnt;
        logic dir_down;
        logic block;
        logic [TMR_PRE_W-1:0] pre;
        logic ovf;
        logic cmf;
        logic pin;
        logic ovr;
        logic osc_en;
        logic external_clock_enable;
        logic as_sel;
        logic d_sel;
        logic d_wr;
        logic [7:0] d_addr;
        logic [31:0] rdata;
        logic ready;
    } tmr_state_type;

    tmr_state_type st_reg;
    tmr_state_type st_next;
    logic slow_edge;
    logic tick;
    logic match;
    logic [1:0] mode;
    logic [1:0] com;
    logic wr_ctl;
    logic wr_cnt;

    // non-PWM pin action, shared by real and forced matches
    function automatic logic act_nonpwm(input logic p, input logic [1:0] c);
        logic r;
        r = p;
        unique case (c)
            TMR_COM_OFF: r = p;
            TMR_COM_TOGGLE: r = ~p;
            TMR_COM_CLEAR: r = 1'b0;
            TMR_COM_SET: r = 1'b1;
        endcase
        return r;
    endfunction

    function automatic logic [9:0] pre_mask(input logic [2:0] cs);
        logic [9:0] m;
        m = TMR_MASK_1;
        unique case (cs)
            3'h0, 3'h1: m = TMR_MASK_1;
            3'h2: m = TMR_MASK_8;
            3'h3: m = TMR_MASK_32;
            3'h4: m = TMR_MASK_64;
            3'h5: m = TMR_MASK_128;
            3'h6: m = TMR_MASK_256;
            3'h7: m = TMR_MASK_1024;
        endcase
        return m;
    endfunction

    assign mode = {st_reg.ctl[TMR_WAVE_HI_BIT], st_reg.ctl[TMR_WAVE_LO_BIT]};
    assign com = st_reg.ctl[TMR_COM_HI:TMR_COM_LO];
    // a rising change counts only once second and third stages are both high
    assign slow_edge = st_reg.sync[1] & st_reg.sync[2] & ~st_reg.slow_lvl;
    assign wr_ctl = st_reg.d_sel & st_reg.d_wr & (st_reg.d_addr == TMR_CTRL_ADDR);
    assign wr_cnt = st_reg.d_sel & st_reg.d_wr & (st_reg.d_addr == TMR_CNT_ADDR);
    // timer clock: slow pin edges or every cycle, through the prescaler
    assign tick = (st_reg.ctl[TMR_CS_HI:0] != 3'h0) // see [RULE13]
        & (st_reg.as_sel ? slow_edge : 1'b1) // see [RULE17]
        & ((st_reg.pre & pre_mask(st_reg.ctl[TMR_CS_HI:0])) == pre_mask(st_reg.ctl[TMR_CS_HI:0]));
    // blocked for one timer clock after a counter write
    assign match = tick & (st_reg.cnt == st_reg.cmp_act) & ~st_reg.block; // see [RULE15] [RULE14]

    // ==========================================================
    // next state
    always_comb begin
        logic set_cmf;
        logic set_ovf;
        logic spec;
        logic [7:0] wd;
        logic [1:0] nmode;
        set_cmf = 1'b0;
        set_ovf = 1'b0;
        spec = (st_reg.cmp_act == TMR_MAX) & com[1];
        wd = hwdata[7:0];
        nmode = {wd[TMR_WAVE_HI_BIT], wd[TMR_WAVE_LO_BIT]};
        st_next = st_reg;
        // pin synchroniser; first stage feeds only the second
        st_next.sync = {st_reg.sync[1:0], slow_clock_pin};
        if (st_reg.sync[1] == st_reg.sync[2]) begin
            st_next.slow_lvl = st_reg.sync[1];
        end
        if (st_reg.as_sel ? slow_edge : 1'b1) begin
            st_next.pre = st_reg.pre + 10'h001;
        end
        // compare level goes straight through in non-PWM modes
        if (mode == TMR_MODE_NORMAL || mode == TMR_MODE_CTC) begin
            st_next.cmp_act = st_reg.cmp_buf; // see [RULE6]
        end
        if (tick) begin
            st_next.block = 1'b0;
        end
        if (match) begin
            set_cmf = 1'b1; // see [RULE22]
        end
        // counting sequence and waveform per mode
        if (tick) begin
            unique case (mode) // see [RULE5]
                TMR_MODE_NORMAL, TMR_MODE_CTC: begin
                    if (mode == TMR_MODE_CTC && match) begin
                        st_next.cnt = TMR_BOTTOM;
                    end else begin
                        st_next.cnt = st_reg.cnt + 8'h01;
                    end
                    if (st_reg.cnt == TMR_MAX) begin
                        set_ovf = 1'b1; // see [RULE6]
                    end
                    if (match) begin
                        st_next.pin = act_nonpwm(st_reg.pin, com); // see [RULE7]
                    end
                end
                TMR_MODE_FAST: begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                    if (match && !spec && com[1]) begin
                        // 10 clears and 11 sets on the match; bottom does the opposite
                        st_next.pin = com[0]; // see [RULE8] [RULE9]
                    end
                    if (st_reg.cnt == TMR_MAX) begin
                        set_ovf = 1'b1;
                        st_next.cmp_act = st_reg.cmp_buf; // see [RULE6]
                        if (com[1]) begin
                            st_next.pin = com[0] ? 1'b0 : 1'b1; // see [RULE8]
                        end
                    end
                end
                TMR_MODE_PHASE: begin
                    if (match && !spec && com[1]) begin
                        st_next.pin = st_reg.dir_down ? ~com[0] : com[0]; // see [RULE10]
                    end
                    if (!st_reg.dir_down && st_reg.cnt == TMR_MAX) begin
                        st_next.dir_down = 1'b1;
                        st_next.cnt = TMR_MAX - 8'h01;
                        st_next.cmp_act = st_reg.cmp_buf; // see [RULE6]
                        if (spec) begin
                            st_next.pin = ~com[0]; // see [RULE11]
                        end
                    end else if (st_reg.dir_down && st_reg.cnt == TMR_BOTTOM) begin
                        st_next.dir_down = 1'b0;
                        st_next.cnt = TMR_BOTTOM + 8'h01;
                        set_ovf = 1'b1; // see [RULE23]
                    end else if (st_reg.dir_down) begin
                        st_next.cnt = st_reg.cnt - 8'h01;
                    end else begin
                        st_next.cnt = st_reg.cnt + 8'h01;
                    end
                end
            endcase
        end
        // async transfers: each temp latches on its second slow edge
        for (int i = 0; i < 3; i++) begin
            if (st_reg.pend[i] && slow_edge) begin
                if (st_reg.ecnt[i] == TMR_LATCH_EDGES - 2'h1) begin
                    st_next.pend[i] = 1'b0; // see [RULE18] [RULE21]
                    st_next.ecnt[i] = 2'h0;
                    if (i == TMR_PEND_CNT) begin
                        st_next.cnt = st_reg.cnt_tmp;
                        st_next.block = 1'b1; // see [RULE14]
                    end else if (i == TMR_PEND_CMP) begin
                        st_next.cmp_buf = st_reg.cmp_tmp;
                    end else begin
                        st_next.ctl = st_reg.ctl_tmp;
                        // forced match uses the freshly latched action, no flag
                        if (st_reg.force_tmp && !st_reg.ctl_tmp[TMR_WAVE_LO_BIT]) begin
                            st_next.pin = act_nonpwm(st_reg.pin,
                                st_reg.ctl_tmp[TMR_COM_HI:TMR_COM_LO]); // see [RULE1] [RULE2]
                        end
                        st_next.force_tmp = 1'b0;
                    end
                end else begin
                    st_next.ecnt[i] = st_reg.ecnt[i] + 2'h1;
                end
            end
        end
        // bus data phase; writes are always taken whole-word, zero wait
        if (wr_ctl) begin
            st_next.ctl_tmp = wd[6:0];
            if (st_reg.as_sel) begin
                st_next.force_tmp = wd[TMR_FORCE_BIT];
                st_next.pend[TMR_PEND_CTL] = 1'b1; // see [RULE18]
                st_next.ecnt[TMR_PEND_CTL] = 2'h0;
            end else begin
                st_next.ctl = wd[6:0];
                if (wd[TMR_FORCE_BIT] && !wd[TMR_WAVE_LO_BIT]) begin
                    // forced match: pin only, counter and flags untouched
                    st_next.pin = act_nonpwm(st_reg.pin,
                        wd[TMR_COM_HI:TMR_COM_LO]); // see [RULE1] [RULE2]
                end
            end
        end
        if (wr_cnt) begin
            st_next.cnt_tmp = wd;
            if (st_reg.as_sel) begin
                st_next.pend[TMR_PEND_CNT] = 1'b1; // see [RULE18]
                st_next.ecnt[TMR_PEND_CNT] = 2'h0;
            end else begin
                st_next.cnt = wd;
                st_next.block = 1'b1; // see [RULE14]
            end
        end
        if (st_reg.d_sel && st_reg.d_wr && st_reg.d_addr == TMR_CMP_ADDR) begin
            st_next.cmp_tmp = wd;
            if (st_reg.as_sel) begin
                st_next.pend[TMR_PEND_CMP] = 1'b1; // see [RULE18]
                st_next.ecnt[TMR_PEND_CMP] = 2'h0;
            end else begin
                st_next.cmp_buf = wd;
            end
        end
        if (st_reg.d_sel && st_reg.d_wr && st_reg.d_addr == TMR_STAT_ADDR) begin
            st_next.external_clock_enable = wd[TMR_EXTERNAL_CLOCK_ENABLE_BIT];
            st_next.as_sel = wd[TMR_ASYNC_BIT]; // see [RULE17]
        end
        // flags: a hardware set in the clearing cycle wins
        st_next.cmf = set_cmf | st_reg.cmf; // see [RULE22]
        st_next.ovf = set_ovf | st_reg.ovf; // see [RULE23]
        if (st_reg.d_sel && st_reg.d_wr && st_reg.d_addr == TMR_FLAG_ADDR) begin
            st_next.cmf = set_cmf | (st_reg.cmf & ~wd[TMR_CMF_BIT]);
            st_next.ovf = set_ovf | (st_reg.ovf & ~wd[TMR_OVF_BIT]);
        end
        // pin side levels, registered so outputs come from flops
        st_next.ovr = st_next.ctl[TMR_COM_HI:TMR_COM_LO] != TMR_COM_OFF; // see [RULE12]
        st_next.osc_en = st_next.as_sel & ~st_next.external_clock_enable; // see [RULE16]
        st_next.ready = 1'b1;
        // bus address phase; read data comes from the post-write state
        st_next.d_sel = hsel & htrans[1] & hready;
        st_next.d_wr = hwrite;
        st_next.d_addr = haddr[7:0];
        st_next.rdata = 32'h0000_0000;
        if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
                TMR_CTRL_ADDR: st_next.rdata[7:0] = {1'b0, st_next.ctl_tmp}; // see [RULE3]
                TMR_CNT_ADDR: st_next.rdata[7:0] = st_next.cnt; // see [RULE20]
                TMR_CMP_ADDR: st_next.rdata[7:0] = st_next.cmp_tmp; // see [RULE20]
                TMR_STAT_ADDR: st_next.rdata[4:0] = {st_next.external_clock_enable, st_next.as_sel, st_next.pend};
                TMR_FLAG_ADDR: st_next.rdata[1:0] = {st_next.cmf, st_next.ovf};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = st_reg.ready;
    assign hresp = 1'b0;
    assign hrdata = st_reg.rdata;
    assign compare_output_pin = st_reg.pin;
    assign compare_output_override = st_reg.ovr;
    assign crystal_osc_enable = st_reg.osc_en;

    // ==========================================================
    // assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic force_now;
    assign force_now = wr_ctl & ~st_reg.as_sel & hwdata[TMR_FORCE_BIT]
        & ~hwdata[TMR_WAVE_LO_BIT] & (hwdata[TMR_CS_HI:0] == 3'h0) & ~tick;

    property p_force_toggle;
        force_now && hwdata[TMR_COM_HI:TMR_COM_LO] == TMR_COM_TOGGLE
            |=> compare_output_pin != $past(compare_output_pin);
    endproperty
    a_force_toggle: assert property (p_force_toggle) // see [RULE1]
        else $error("force did not toggle");

    property p_force_quiet;
        force_now |=> !$rose(st_reg.cmf) && st_reg.cnt == $past(st_reg.cnt);
    endproperty
    a_force_quiet: assert property (p_force_quiet) // see [RULE2]
        else $error("force touched flag or counter");

    property p_force_reads_zero;
        st_next.d_sel && !hwrite && haddr[7:0] == TMR_CTRL_ADDR |=> hrdata[TMR_FORCE_BIT] == 1'b0;
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero) // see [RULE3]
        else $error("force bit read one");

    property p_ctc_clear;
        mode == TMR_MODE_CTC && match && !wr_cnt && st_reg.pend == 3'h0
            |=> st_reg.cnt == TMR_BOTTOM;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("no clear at compare"); // see [RULE5]

    property p_stopped;
        st_reg.ctl[TMR_CS_HI:0] == 3'h0 && !wr_cnt && st_reg.pend == 3'h0 |=> $stable(st_reg.cnt);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved"); // see [RULE13]

    property p_block;
        // a clear flag must stay clear across the blocked timer clock
        tick && st_reg.block && !st_reg.cmf |=> !st_reg.cmf;
    endproperty
    a_block: assert property (p_block) else $error("match after counter write"); // see [RULE14]

    property p_pend_set;
        wr_cnt && st_reg.as_sel |=> st_reg.pend[TMR_PEND_CNT];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set"); // see [RULE18]

    property p_two_edges;
        $fell(st_reg.pend[TMR_PEND_CMP])
            |-> $past(slow_edge) && $past(st_reg.ecnt[TMR_PEND_CMP]) == 2'h1;
    endproperty
    a_two_edges: assert property (p_two_edges) // see [RULE21]
        else $error("latched before second edge");

    property p_set_wins;
        match ##0 st_reg.d_sel && st_reg.d_wr && st_reg.d_addr == TMR_FLAG_ADDR |=> st_reg.cmf;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost to clear"); // see [RULE22]

    property p_osc;
        crystal_osc_enable == (st_reg.as_sel && !st_reg.external_clock_enable);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong"); // see [RULE16]

    c_force: cover property (force_now);
    c_async_latch: cover property ($fell(st_reg.pend[TMR_PEND_CTL]));
    c_phase_ovf: cover property (mode == TMR_MODE_PHASE && tick && st_reg.dir_down
        && st_reg.cnt == TMR_BOTTOM);
    c_fast_match: cover property (mode == TMR_MODE_FAST && match);
endmodule

//--- inc/tmr_pkg.sv
// Operation
// [RULE1] force strobe in non-PWM mode acts at once like a compare match on the pin
// [RULE2] force strobe raises no flag and never clears the counter
// [RULE3] force strobe bit always reads back as zero
// [RULE4] software keeps force strobe zero when writing control in a PWM mode
// [RULE5] wave mode 00 normal, 01 phase PWM, 10 clear-on-compare, 11 fast PWM
// [RULE6] compare level updates per mode; overflow at MAX, phase PWM at BOTTOM
// [RULE7] non-PWM action: 00 off, 01 toggle, 10 clear, 11 set on match
// [RULE8] fast PWM action: 10 clear on match set at BOTTOM, 11 inverse
// [RULE9] fast PWM with compare at TOP and action bit 1: only BOTTOM action
// [RULE10] phase PWM 10 clears on up match, sets on down match; 11 inverse
// [RULE11] phase PWM with compare at TOP and action bit 1: act at TOP instead
// [RULE12] nonzero action overrides the pin; software still sets pin direction
// [RULE13] clock select: stop, undivided, then /8 /32 /64 /128 /256 /1024
// [RULE14] counter write blocks the match on next timer clock; counter is 8-bit
// [RULE15] compare level is compared with the counter continuously
// [RULE16] external clock enable with async select takes pin clock, stops crystal
// [RULE17] async select picks I/O clock (0) or slow clock pin (1)
// [RULE18] async writes set their own pending bit until the value is latched
// [RULE19] software never writes a register whose pending bit is set
// [RULE20] counter reads actual value; compare and control read temporary storage
// [RULE21] async write reaches its register after two rising slow clock edges
// [RULE22] compare flag set on match, cleared by writing one
// [RULE23] overflow flag set per mode, cleared by writing one
package tmr_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] TMR_CTRL_ADDR = 8'h00;
    localparam logic [7:0] TMR_CNT_ADDR = 8'h04;
    localparam logic [7:0] TMR_CMP_ADDR = 8'h08;
    localparam logic [7:0] TMR_STAT_ADDR = 8'h0c;
    localparam logic [7:0] TMR_FLAG_ADDR = 8'h10;
    // ==========================================================
    // control fields
    localparam int TMR_FORCE_BIT = 7;
    localparam int TMR_WAVE_LO_BIT = 6;
    localparam int TMR_COM_HI = 5;
    localparam int TMR_COM_LO = 4;
    localparam int TMR_WAVE_HI_BIT = 3;
    localparam int TMR_CS_HI = 2;
    // status fields
    localparam int TMR_EXTERNAL_CLOCK_ENABLE_BIT = 4;
    localparam int TMR_ASYNC_BIT = 3;
    localparam int TMR_PEND_CNT = 2;
    localparam int TMR_PEND_CMP = 1;
    localparam int TMR_PEND_CTL = 0;
    // flag fields
    localparam int TMR_CMF_BIT = 1;
    localparam int TMR_OVF_BIT = 0;
    // ==========================================================
    // counter values and timing
    localparam logic [7:0] TMR_MAX = 8'hff;
    localparam logic [7:0] TMR_BOTTOM = 8'h00;
    localparam int TMR_PRE_W = 10;
    localparam logic [1:0] TMR_LATCH_EDGES = 2'h2;
    localparam logic [9:0] TMR_MASK_1 = 10'h000;
    localparam logic [9:0] TMR_MASK_8 = 10'h007;
    localparam logic [9:0] TMR_MASK_32 = 10'h01f;
    localparam logic [9:0] TMR_MASK_64 = 10'h03f;
    localparam logic [9:0] TMR_MASK_128 = 10'h07f;
    localparam logic [9:0] TMR_MASK_256 = 10'h0ff;
    localparam logic [9:0] TMR_MASK_1024 = 10'h3ff;
    // ==========================================================
    // wave modes as {high bit, low bit}
    localparam logic [1:0] TMR_MODE_NORMAL = 2'h0;
    localparam logic [1:0] TMR_MODE_PHASE = 2'h1;
    localparam logic [1:0] TMR_MODE_CTC = 2'h2;
    localparam logic [1:0] TMR_MODE_FAST = 2'h3;
    // pin actions
    localparam logic [1:0] TMR_COM_OFF = 2'h0;
    localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
    localparam logic [1:0] TMR_COM_SET = 2'h3;
endpackage

//--- verification/tmr_slow_src.sv
`timescale 1ns/100ps
// ==========================================================
// external slow clock source on the slow clock pin
module tmr_slow_src #(
    parameter int HALF_NS = 43
) (
    input wire logic run,
    output logic slow_clock_pin
);
    // the pin stands low whenever the source is stopped, so no edge leaks in
    initial slow_clock_pin = 1'b0;
    // odd half period keeps the phase unrelated to hclk; each level >= 3 hclk
    always begin
        wait (run === 1'b1);
        #(HALF_NS) slow_clock_pin = 1'b1;
        #(HALF_NS) slow_clock_pin = 1'b0;
    end
endmodule

//--- verification/async_8bit_timer_with_compare_tb.sv
`timescale 1ns/100ps
module async_8bit_timer_with_compare_tb;
    import tmr_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, slow_clock_pin, compare_output_pin;
    logic compare_output_override, crystal_osc_enable;
    logic [31:0] hrdata, v;
    int miscompares = 0, n_compared = 0, n;
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    tmr_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .slow_clock_pin(slow_clock_pin), .compare_output_pin(compare_output_pin),
        .compare_output_override(compare_output_override),
        .crystal_osc_enable(crystal_osc_enable));
    tmr_slow_src src_u (.run(run), .slow_clock_pin(slow_clock_pin));
    // ==========================================================
    // bus cycles and comparison
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask
    // length of the next whole stretch of the pin at level lv, in hclk cycles
    task automatic span(input logic lv, output int n);
        int k = 0;
        while (compare_output_pin === lv && k < 3000) begin
            @(posedge hclk);
            k++;
        end
        while (compare_output_pin !== lv && k < 3000) begin
            @(posedge hclk);
            k++;
        end
        n = 0;
        while (compare_output_pin === lv && n < 3000) begin
            @(posedge hclk);
            n++;
        end
    endtask
    // cycles in a window of len hclk during which the pin is not high
    task automatic low_count(input int len, output int n);
        n = 0;
        repeat (len) begin
            @(posedge hclk);
            n += (compare_output_pin !== 1'b1);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_force();
        rd(8'h20, v);
        chk(v, 32'h0); // unmapped reads zero
        chk(hresp, 1'b0); // response is always okay
        wr(TMR_CMP_ADDR, 8'h09);
        wr(TMR_CNT_ADDR, 8'h05);
        wr(TMR_CTRL_ADDR, 8'h98);
        #1 chk(compare_output_pin, 1'b1);
        wr(TMR_CTRL_ADDR, 8'ha8);
        #1 chk(compare_output_pin, 1'b0);
        wr(TMR_CTRL_ADDR, 8'hb8);
        #1 chk(compare_output_pin, 1'b1);
        chk(compare_output_override, 1'b1);
        rd(TMR_CTRL_ADDR, v);
        chk(v, 32'h38);
        rd(TMR_CNT_ADDR, v);
        chk(v, 32'h05);
        rd(TMR_FLAG_ADDR, v);
        chk(v, 32'h0);
        wr(TMR_CTRL_ADDR, 8'h08);
        #1 chk(compare_output_override, 1'b0);
        $display("t_force done");
    endtask
    task automatic t_presc();
        int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
        for (int c = 0; c < 8; c++) begin
            wr(TMR_CTRL_ADDR, 8'(c));
            wr(TMR_CNT_ADDR, 8'h00);
            repeat (c > 0 ? 4 * dv[c] - 1 : 40) @(posedge hclk);
            rd(TMR_CNT_ADDR, v);
            chk(c > 0 ? (v >= 3 && v <= 5) : v == 0, 1'b1);
        end
        $display("t_presc done");
    endtask
    // ctc with toggle: top is the compare level, pin period 10 ticks each way
    task automatic t_ctc();
        wr(TMR_CTRL_ADDR, 8'h00);
        wr(TMR_CNT_ADDR, 8'h00);
        wr(TMR_FLAG_ADDR, 8'h03);
        wr(TMR_CTRL_ADDR, 8'h19);
        span(1'b1, n);
        chk(n, 10);
        rd(TMR_CNT_ADDR, v);
        chk(v <= 9, 1'b1);
        rd(TMR_FLAG_ADDR, v);
        chk(v, 32'h2);
        wr(TMR_CTRL_ADDR, 8'h00);
        wr(TMR_FLAG_ADDR, 8'h03);
        rd(TMR_FLAG_ADDR, v);
        chk(v, 32'h0);
        $display("t_ctc done");
    endtask
    task automatic t_fast();
        wr(TMR_CMP_ADDR, 8'h3f);
        wr(TMR_CTRL_ADDR, 8'h69);
        span(1'b1, n);
        chk(n, 64);
        rd(TMR_FLAG_ADDR, v);
        chk(v[0], 1'b1);
        wr(TMR_CMP_ADDR, 8'hff);
        repeat (600) @(posedge hclk);
        low_count(300, n);
        chk(n, 0);
        $display("t_fast done");
    endtask
    // low stretch runs from the up match at 0x40 over the top to the down match
    task automatic t_phase();
        wr(TMR_CTRL_ADDR, 8'h00);
        wr(TMR_CMP_ADDR, 8'h40);
        wr(TMR_CNT_ADDR, 8'h00);
        wr(TMR_FLAG_ADDR, 8'h03);
        wr(TMR_CTRL_ADDR, 8'h61);
        span(1'b0, n);
        chk(n, 382);
        // the bottom turn comes about 0x40 timer clocks after the down match
        repeat (100) @(posedge hclk);
        rd(TMR_FLAG_ADDR, v);
        chk(v[0], 1'b1);
        // compare level at top reloads at the top turn; two periods to settle
        wr(TMR_CMP_ADDR, 8'hff);
        repeat (1100) @(posedge hclk);
        low_count(600, n);
        chk(n, 0);
        wr(TMR_CTRL_ADDR, 8'h00);
        $display("t_phase done");
    endtask
    // async writes wait in temp storage for two slow clock edges
    task automatic t_async();
        logic [7:0] ad[3] = '{TMR_CNT_ADDR, TMR_CMP_ADDR, TMR_CTRL_ADDR};
        logic [7:0] dat[3] = '{8'h77, 8'h55, 8'h08};
        // external clock enable goes in before async select
        wr(TMR_STAT_ADDR, 8'h10);
        #1 chk(crystal_osc_enable, 1'b0);
        wr(TMR_STAT_ADDR, 8'h18);
        #1 chk(crystal_osc_enable, 1'b0);
        rd(TMR_STAT_ADDR, v);
        chk(v, 32'h18);
        for (int i = 0; i < 3; i++) begin
            wr(ad[i], dat[i]);
            rd(TMR_STAT_ADDR, v);
            chk(v[2 - i], 1'b1);
            if (i > 0) begin
                rd(ad[i], v);
                chk(v, 32'(dat[i]));
            end
            run <= 1'b1;
            @(posedge slow_clock_pin);
            run <= 1'b0;
            repeat (6) @(posedge hclk);
            rd(TMR_STAT_ADDR, v);
            chk(v[2 - i], 1'b1);
            run <= 1'b1;
            @(posedge slow_clock_pin);
            run <= 1'b0;
            repeat (6) @(posedge hclk);
            // the next write waits for this pending bit to drop
            rd(TMR_STAT_ADDR, v);
            chk(v[2 - i], 1'b0);
            rd(ad[i], v);
            chk(v, 32'(dat[i]));
        end
        // back to sync, then crystal async with external clock off
        wr(TMR_STAT_ADDR, 8'h00);
        wr(TMR_STAT_ADDR, 8'h08);
        #1 chk(crystal_osc_enable, 1'b1);
        $display("t_async done");
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_force();
        t_presc();
        t_ctc();
        t_fast();
        t_phase();
        t_async();
        close_out();
    end
    // the tests need about 10k cycles; a hang is cut well beyond that
    initial begin
        repeat (50000) @(posedge hclk);
        miscompares++;
        close_out();
    end
endmodule
